// ### hw/iss_top.sv
/*
 * I2C slave port: byte engine, access status flags, bus event flags and
 * interrupt requests, with a plain register port.
 * Assumes an external master on the two lines and a bus clock well under
 * one eighth of CLOCK_I; no clock stretching is done.
 */
// Added by the designer: the plain strobed port.
`include "iss_defines.svh"

module iss_top (
    // clock and reset
    input  wire logic             CLOCK_I,
    input  wire logic             SYS_RST_I,
    // register port
    input  wire iss_pkg::iss_req_t BUS_REQ_I,
    output logic [15:0]           BUS_RDATA_O,
    // two-wire bus
    input  wire logic             BUS_CLOCK_LINE_I,
    input  wire logic             BUS_DATA_LINE_I,
    output logic                  BUS_DATA_LINE_O,
    output logic                  BUS_DATA_LINE_OE_N_O,
    // interrupt requests
    output logic                  IRQ_BUS_O,
    output logic                  IRQ_RX_O,
    output logic                  IRQ_TX_O,
    output logic                  IRQ_O
);
    import iss_pkg::*;

    iss_line_t          ln;
    iss_state_t         state;
    logic [2:0]         bit_cnt;
    logic [7:0]         shreg;
    logic [6:0]         own_addr;
    logic [7:0]         rx_hold;
    logic [7:0]         tx_hold;
    logic               dir;
    logic               addressed;
    logic               busy;
    logic               stop_flag;
    logic               nak_flag;
    logic               rx_ready;
    logic               tx_empty;
    logic [`ISS_IE_W-1:0] irq_en;
    logic               bus_event_summary;
    logic               frame_evt;
    logic               stop_evt;
    logic               addr_match;
    logic               rx_load;
    logic               tx_load;
    logic               nak_evt;
    logic               rd_rx;
    logic               wr_tx;
    logic               clr_stop;
    logic               clr_nak;
    logic               next_irq_bus;
    logic               next_irq_rx;
    logic               next_irq_tx;

    function automatic logic hit(input iss_req_t r, input logic [15:0] off);
        hit = (r.addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // line conditioning
    iss_line_sync u_sync (
        .clk_i  (CLOCK_I),
        .rst_i  (SYS_RST_I),
        .scl_i  (BUS_CLOCK_LINE_I),
        .sda_i  (BUS_DATA_LINE_I),
        .line_o (ln)
    );

    ////////////////////////////////////////////////////////////////////////////
    // events of the byte engine
    always_comb begin
        frame_evt  = ln.start | ln.stop;
        stop_evt   = addressed & frame_evt;
        addr_match = (state == S_ADDR) & ln.scl_rise & ~frame_evt
                     & (bit_cnt == `ISS_LAST_BIT) & (shreg[6:0] == own_addr);
        rx_load    = (state == S_WR_DATA) & ln.scl_rise & ~frame_evt
                     & (bit_cnt == `ISS_LAST_BIT);
        tx_load    = ln.scl_fall & ~frame_evt
                     & (((state == S_ACK) & dir) | (state == S_RD_NEXT));
        nak_evt    = (state == S_RD_ACK) & ln.scl_rise & ~frame_evt & ln.sda;
        rd_rx      = BUS_REQ_I.rd & hit(BUS_REQ_I, `ISS_OFF_RX_HOLD);
        wr_tx      = BUS_REQ_I.wr & hit(BUS_REQ_I, `ISS_OFF_TX_HOLD);
        clr_stop   = BUS_REQ_I.wr & BUS_REQ_I.wdata[`ISS_EV_STOP]
                     & (hit(BUS_REQ_I, `ISS_OFF_BUS_EVENT) | hit(BUS_REQ_I, `ISS_OFF_IRQ_CLR));
        clr_nak    = BUS_REQ_I.wr & BUS_REQ_I.wdata[`ISS_EV_NAK]
                     & (hit(BUS_REQ_I, `ISS_OFF_BUS_EVENT) | hit(BUS_REQ_I, `ISS_OFF_IRQ_CLR));
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte engine; a stop or a start always wins over bit traffic
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            state    <= S_IDLE;
            bit_cnt  <= `ISS_CNT_RST;
            shreg    <= `ISS_BYTE_RST;
            BUS_DATA_LINE_OE_N_O <= 1'b1;
        end else if (ln.stop) begin
            state    <= S_IDLE;
            BUS_DATA_LINE_OE_N_O <= 1'b1;
        end else if (ln.start) begin
            state    <= S_ADDR;
            bit_cnt  <= `ISS_CNT_RST;
            BUS_DATA_LINE_OE_N_O <= 1'b1;
        end else begin
            case (state)
                S_ADDR, S_WR_DATA: begin
                    if (ln.scl_rise) begin
                        shreg   <= {shreg[6:0], ln.sda};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == `ISS_LAST_BIT) begin
                            // a foreign address leaves the engine idle until the next start
                            state <= (state == S_WR_DATA || addr_match) ? S_ACK_WAIT : S_IDLE;
                        end
                    end
                end
                S_ACK_WAIT: begin
                    if (ln.scl_fall) begin
                        BUS_DATA_LINE_OE_N_O <= 1'b0;
                        state <= S_ACK;
                    end
                end
                S_ACK: begin
                    if (ln.scl_fall) begin
                        bit_cnt <= `ISS_CNT_RST;
                        if (dir) begin
                            shreg <= tx_hold;
                            BUS_DATA_LINE_OE_N_O <= tx_hold[7];
                            state <= S_RD_DATA;
                        end else begin
                            BUS_DATA_LINE_OE_N_O <= 1'b1;
                            state <= S_WR_DATA;
                        end
                    end
                end
                S_RD_DATA: begin
                    if (ln.scl_fall) begin
                        if (bit_cnt == `ISS_LAST_BIT) begin
                            BUS_DATA_LINE_OE_N_O <= 1'b1;
                            state <= S_RD_ACK;
                        end else begin
                            bit_cnt <= bit_cnt + 3'h1;
                            shreg   <= {shreg[6:0], 1'b0};
                            BUS_DATA_LINE_OE_N_O <= shreg[6];
                        end
                    end
                end
                S_RD_ACK: begin
                    if (ln.scl_rise) begin
                        state <= ln.sda ? S_IDLE : S_RD_NEXT;
                    end
                end
                S_RD_NEXT: begin
                    if (ln.scl_fall) begin
                        bit_cnt <= `ISS_CNT_RST;
                        shreg   <= tx_hold;
                        BUS_DATA_LINE_OE_N_O <= tx_hold[7];
                        state   <= S_RD_DATA;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // the pin is only ever pulled low; the level when enabled is always zero
    always_ff @(posedge CLOCK_I) begin
        BUS_DATA_LINE_O <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // access state: busy, addressed, direction
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            busy <= 1'b0;
        end else if (ln.start | ~ln.scl | ~ln.sda) begin
            busy <= 1'b1;
        end else if (ln.stop) begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            addressed <= 1'b0;
            dir       <= 1'b0;
        end else if (frame_evt) begin
            addressed <= 1'b0;
        end else if (addr_match) begin
            addressed <= 1'b1;
            dir       <= ln.sda;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags; a hardware set beats a clear in the same cycle
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            stop_flag <= 1'b0;
        end else if (stop_evt) begin
            stop_flag <= 1'b1;
        end else if (clr_stop) begin
            stop_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            nak_flag <= 1'b0;
        end else if (nak_evt) begin
            nak_flag <= 1'b1;
        end else if (clr_nak) begin
            nak_flag <= 1'b0;
        end
    end

    assign bus_event_summary = stop_flag | nak_flag;

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            rx_ready <= 1'b0;
            rx_hold  <= `ISS_BYTE_RST;
        end else if (rx_load) begin
            rx_ready <= 1'b1;
            rx_hold  <= {shreg[6:0], ln.sda};
        end else if (rd_rx) begin
            rx_ready <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            tx_empty <= 1'b0;
        end else if (tx_load) begin
            tx_empty <= 1'b1;
        end else if (wr_tx) begin
            tx_empty <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-written registers
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            irq_en   <= `ISS_IRQ_EN_RST;
            own_addr <= `ISS_OWN_ADDR_RST;
            tx_hold  <= `ISS_BYTE_RST;
        end else if (BUS_REQ_I.wr) begin
            if (hit(BUS_REQ_I, `ISS_OFF_IRQ_EN)) begin
                irq_en <= BUS_REQ_I.wdata[`ISS_IE_W-1:0];
            end
            if (hit(BUS_REQ_I, `ISS_OFF_OWN_ADDR)) begin
                own_addr <= BUS_REQ_I.wdata[6:0];
            end
            if (wr_tx) begin
                tx_hold <= BUS_REQ_I.wdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, present only in the cycle after the read strobe
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I || !BUS_REQ_I.rd) begin
            BUS_RDATA_O <= `ISS_RDATA_RST;
        end else begin
            BUS_RDATA_O <= `ISS_RDATA_RST;
            case (BUS_REQ_I.addr)
                `ISS_OFF_OWN_ADDR: BUS_RDATA_O[6:0] <= own_addr;
                `ISS_OFF_RX_HOLD:  BUS_RDATA_O[7:0] <= rx_hold;
                `ISS_OFF_TX_HOLD:  BUS_RDATA_O[7:0] <= tx_hold;
                `ISS_OFF_BUS_EVENT: begin
                    BUS_RDATA_O[`ISS_EV_STOP]    <= stop_flag;
                    BUS_RDATA_O[`ISS_EV_NAK]     <= nak_flag;
                    BUS_RDATA_O[`ISS_EV_SUMMARY] <= bus_event_summary;
                end
                `ISS_OFF_ACCESS: begin
                    BUS_RDATA_O[`ISS_AS_DIR]       <= dir;
                    BUS_RDATA_O[`ISS_AS_ADDRESSED] <= addressed;
                    BUS_RDATA_O[`ISS_AS_BUSY]      <= busy;
                    BUS_RDATA_O[`ISS_AS_TX_EMPTY]  <= tx_empty;
                    BUS_RDATA_O[`ISS_AS_RX_READY]  <= rx_ready;
                end
                `ISS_OFF_IRQ_EN:   BUS_RDATA_O[`ISS_IE_W-1:0] <= irq_en;
                default:           BUS_RDATA_O <= `ISS_RDATA_RST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt requests: levels, one cycle behind their flags
    always_comb begin
        next_irq_bus = bus_event_summary & irq_en[`ISS_IE_BUS];
        next_irq_rx  = rx_ready & irq_en[`ISS_IE_RX];
        next_irq_tx  = tx_empty & irq_en[`ISS_IE_TX];
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            IRQ_BUS_O <= 1'b0;
            IRQ_RX_O  <= 1'b0;
            IRQ_TX_O  <= 1'b0;
            IRQ_O     <= 1'b0;
        end else begin
            IRQ_BUS_O <= next_irq_bus;
            IRQ_RX_O  <= next_irq_rx;
            IRQ_TX_O  <= next_irq_tx;
            IRQ_O     <= next_irq_bus | next_irq_rx | next_irq_tx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (SYS_RST_I);

    sequence s_frame_end_addressed;
        addressed && (ln.stop || ln.start);
    endsequence
    sequence s_bus_irq_cause;
        (stop_flag && irq_en[`ISS_IE_BUS]) [*2];
    endsequence
    a_stop_flag_set: assert property (s_frame_end_addressed |=> stop_flag && !addressed)
        else $error("stop flag not set on addressed frame end");
    a_stop_flag_hold: assert property (stop_flag && !clr_stop |=> stop_flag)
        else $error("stop flag dropped without a clear");
    a_bus_irq_gate: assert property (s_bus_irq_cause |-> IRQ_BUS_O && IRQ_O)
        else $error("bus event interrupt missing");
    a_bus_irq_off: assert property (!irq_en[`ISS_IE_BUS] [*2] |-> !IRQ_BUS_O)
        else $error("bus event interrupt while disabled");
    a_rx_irq_level: assert property ((rx_ready && irq_en[`ISS_IE_RX]) [*2] |-> IRQ_RX_O)
        else $error("receive interrupt missing");
    a_rx_read_clear: assert property (rd_rx && !rx_load |=> !rx_ready ##1 !IRQ_RX_O)
        else $error("receive ready not cleared by read");
    a_tx_write_clear: assert property (wr_tx && !tx_load |=> !tx_empty ##1 !IRQ_TX_O)
        else $error("transmit empty not cleared by write");
    a_busy_on_low: assert property (!ln.scl || !ln.sda |=> busy)
        else $error("busy not set on low line");
    a_busy_hold: assert property (busy && !ln.stop |=> busy)
        else $error("busy cleared without stop");
    a_addr_stable: assert property (addressed && !frame_evt |=> $stable(dir))
        else $error("direction changed while addressed");

endmodule

// ### hw/iss_defines.svh
/*
 * Register offsets, bit positions and reset values of the I2C slave
 * status and interrupt block.
 * Assumes inclusion by bare name from any design file of the block.
 */
`ifndef ISS_DEFINES_SVH
`define ISS_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets (16-bit register port addresses)
`define ISS_OFF_OWN_ADDR   16'h4362
`define ISS_OFF_RX_HOLD    16'h4364
`define ISS_OFF_TX_HOLD    16'h4366
`define ISS_OFF_BUS_EVENT  16'h4368
`define ISS_OFF_ACCESS     16'h436a
`define ISS_OFF_IRQ_EN     16'h436c
`define ISS_OFF_IRQ_CLR    16'h436e

////////////////////////////////////////////////////////////////////////////////
// bus_event_reg and irq clear register layout
`define ISS_EV_STOP        0
`define ISS_EV_NAK         1
`define ISS_EV_SUMMARY     7

// access_state_reg layout
`define ISS_AS_DIR         0
`define ISS_AS_ADDRESSED   1
`define ISS_AS_BUSY        2
`define ISS_AS_TX_EMPTY    3
`define ISS_AS_RX_READY    4

// irq_enable_reg layout
`define ISS_IE_TX          0
`define ISS_IE_RX          1
`define ISS_IE_BUS         2
`define ISS_IE_W           3

////////////////////////////////////////////////////////////////////////////////
// reset values and counts
`define ISS_IRQ_EN_RST     3'h0
`define ISS_OWN_ADDR_RST   7'h2a
`define ISS_BYTE_RST       8'h00
`define ISS_RDATA_RST      16'h0000
`define ISS_CNT_RST        3'h0
`define ISS_LAST_BIT       3'h7

`endif

// ### hw/iss_pkg.sv
/*
 * Types shared by the I2C slave status and interrupt block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package iss_pkg;

    // one register port request, valid in the cycle of its strobe
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } iss_req_t;

    // synchronised line levels and bus conditions
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } iss_line_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ACK_WAIT,
        S_ACK,
        S_WR_DATA,
        S_RD_DATA,
        S_RD_ACK,
        S_RD_NEXT
    } iss_state_t;

endpackage

// ### hw/iss_line_sync.sv
/*
 * Two-flop synchronisers for the bus clock and data lines, with edge and
 * start/stop condition detection on the synchronised levels.
 * Assumes the lines are asynchronous to clk_i and at most one eighth of its rate.
 */
module iss_line_sync
    import iss_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // raw lines
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    // conditioned view
    output iss_pkg::iss_line_t line_o
);

    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic       scl_prev;
    logic       sda_prev;

    ////////////////////////////////////////////////////////////////////////////
    // lines idle high, so reset to high to avoid a false start after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= {scl_meta[0], scl_i};
            sda_meta <= {sda_meta[0], sda_i};
            scl_prev <= scl_meta[1];
            sda_prev <= sda_meta[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // only the second stage and the delayed copy are looked at
    always_comb begin
        line_o.scl      = scl_meta[1];
        line_o.sda      = sda_meta[1];
        line_o.scl_rise = scl_meta[1] & ~scl_prev;
        line_o.scl_fall = ~scl_meta[1] & scl_prev;
        line_o.start    = scl_meta[1] & scl_prev & sda_prev & ~sda_meta[1];
        line_o.stop     = scl_meta[1] & scl_prev & ~sda_prev & sda_meta[1];
    end

endmodule

// ### tb/iss_tb_master.sv
/*
 * Behavioural two-wire bus master driving the slave port under test.
 * Assumes pull-ups on both lines; sda_line_i is the resolved data line.
 */
module iss_tb_master (
    // resolved data line
    input  wire logic sda_line_i,
    // driven lines, 1 = released
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // clock line stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // late data edge leaves room for the slave to let go of its ack first
    task automatic start_cond();
        #30 sda_o = 1'b1;
        #30 scl_o = 1'b1;
        #20 sda_o = 1'b0;
        #20 scl_o = 1'b0;
    endtask

    task automatic stop_cond();
        #25 sda_o = 1'b0;
        #25 scl_o = 1'b1;
        #20 sda_o = 1'b1;
        #40;
    endtask

    // one 80 ns bit, sampled 15 ns into its 30 ns high phase
    task automatic put_bit(input logic b, output logic r);
        #25 sda_o = b;
        #25 scl_o = 1'b1;
        #15 r = sda_line_i;
        #15 scl_o = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, ack);
    endtask

    task automatic get_byte(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(nak, r);
    endtask
endmodule

// ### tb/iss_top_tb_top.sv
/*
 * Self-checking bench of the slave port status and interrupt block.
 * Assumes the design sources and iss_defines.svh are compiled first.
 */
`include "iss_defines.svh"

module iss_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import iss_pkg::*;

    logic        clock;
    logic        rst;
    iss_req_t    req;
    logic [15:0] rdata;
    logic        scl;
    logic        m_sda;
    logic        dout;
    logic        oe_n;
    wire         sda_line;
    wire  [3:0]  irq;
    int          failures;
    int          checked;
    // reference model of the flags
    logic        rxr, txe, busy, sel, dir;
    logic [2:0]  en;
    logic [1:0]  ev;
    logic [7:0]  b;
    logic [7:0]  g;
    logic        ack;
    // bytes in flight between software and the master, oldest first
    logic [7:0]  byte_q[$];

    assign sda_line = m_sda & (oe_n | dout);

    always #5 clock = ~clock;

    iss_top dut (
        .CLOCK_I(clock), .SYS_RST_I(rst), .BUS_REQ_I(req), .BUS_RDATA_O(rdata),
        .BUS_CLOCK_LINE_I(scl), .BUS_DATA_LINE_I(sda_line), .BUS_DATA_LINE_O(dout),
        .BUS_DATA_LINE_OE_N_O(oe_n), .IRQ_BUS_O(irq[2]), .IRQ_RX_O(irq[1]),
        .IRQ_TX_O(irq[0]), .IRQ_O(irq[3])
    );

    iss_tb_master master (.sda_line_i(sda_line), .scl_o(scl), .sda_o(m_sda));

    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [15:0] gv, input logic [15:0] e);
        checked++;
        if (gv !== e) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, gv, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req <= '0;
        @(posedge clock);
    endtask

    task automatic chk_reg(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req <= '0;
        #1 d = rdata;
        @(posedge clock);
        cmp(d, e);
    endtask

    // outputs lag their flags by one registered stage
    task automatic chk_irq();
        logic [3:0] e;
        e[2:0] = {(ev != 2'h0) & en[2], rxr & en[1], txe & en[0]};
        e[3] = |e[2:0];
        repeat (2) @(posedge clock);
        #1 cmp({12'h000, irq}, {12'h000, e});
        @(posedge clock);
    endtask

    function automatic logic [15:0] as_exp();
        return {11'h000, rxr, txe, busy, sel, dir};
    endfunction

    function automatic logic [15:0] ev_exp();
        return {8'h00, |ev, 5'h00, ev};
    endfunction

    task automatic settle();
        repeat (6) @(posedge clock);
    endtask

    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #500_000;
        failures++;
        wrap_up();
    end

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        req = '0;
        failures = 0;
        checked = 0;
        {rxr, txe, busy, sel, dir} = 5'h00;
        en = 3'h0;
        ev = 2'h0;
        void'($urandom(32'hea088bb1));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        chk_reg(`ISS_OFF_IRQ_EN, 16'h0000);
        chk_reg(16'h4000, 16'h0000);
        en = 3'h7;
        wr(`ISS_OFF_IRQ_EN, 16'h0007);
        chk_reg(`ISS_OFF_IRQ_EN, 16'h0007);
        // master write of one random byte
        master.start_cond();
        busy = 1'b1;
        settle();
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        master.send_byte({`ISS_OWN_ADDR_RST, 1'b0}, ack);
        sel = 1'b1;
        cmp({15'h0000, ack}, 16'h0000);
        b = 8'($urandom);
        byte_q.push_back(b);
        master.send_byte(b, ack);
        rxr = 1'b1;
        settle();
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        chk_irq();
        chk_reg(`ISS_OFF_RX_HOLD, {8'h00, byte_q.pop_front()});
        rxr = 1'b0;
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        master.stop_cond();
        {busy, sel, ev} = 4'h1;
        settle();
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        chk_reg(`ISS_OFF_BUS_EVENT, ev_exp());
        chk_irq();
        en = 3'h3;
        wr(`ISS_OFF_IRQ_EN, 16'h0003);
        chk_irq();
        en = 3'h7;
        wr(`ISS_OFF_IRQ_EN, 16'h0007);
        chk_reg(`ISS_OFF_BUS_EVENT, ev_exp());
        wr(`ISS_OFF_BUS_EVENT, 16'h0001);
        ev = 2'h0;
        chk_reg(`ISS_OFF_BUS_EVENT, ev_exp());
        // master read ended by a refusal
        b = 8'($urandom);
        byte_q.push_back(b);
        wr(`ISS_OFF_TX_HOLD, {8'h00, b});
        master.start_cond();
        master.send_byte({`ISS_OWN_ADDR_RST, 1'b1}, ack);
        {busy, sel, dir, txe} = 4'hf;
        settle();
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        chk_irq();
        master.get_byte(1'b1, g);
        cmp({8'h00, g}, {8'h00, byte_q.pop_front()});
        master.stop_cond();
        {busy, sel, ev} = 4'h3;
        settle();
        chk_reg(`ISS_OFF_BUS_EVENT, ev_exp());
        wr(`ISS_OFF_BUS_EVENT, 16'h0001);
        ev = 2'h2;
        chk_reg(`ISS_OFF_BUS_EVENT, ev_exp());
        wr(`ISS_OFF_IRQ_CLR, 16'h0002);
        ev = 2'h0;
        wr(`ISS_OFF_TX_HOLD, 16'h005a);
        txe = 1'b0;
        chk_reg(`ISS_OFF_TX_HOLD, 16'h005a);
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        chk_irq();
        // foreign address: busy but never addressed
        master.start_cond();
        master.send_byte({7'h55, 1'b1}, ack);
        busy = 1'b1;
        cmp({15'h0000, ack}, 16'h0001);
        settle();
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        master.stop_cond();
        busy = 1'b0;
        settle();
        chk_reg(`ISS_OFF_BUS_EVENT, ev_exp());
        // repeated start while addressed
        master.start_cond();
        master.send_byte({`ISS_OWN_ADDR_RST, 1'b0}, ack);
        master.start_cond();
        {busy, sel, dir, ev} = 5'h11;
        settle();
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        chk_reg(`ISS_OFF_BUS_EVENT, ev_exp());
        master.stop_cond();
        busy = 1'b0;
        settle();
        chk_reg(`ISS_OFF_ACCESS, as_exp());
        wr(`ISS_OFF_IRQ_CLR, 16'h0001);
        ev = 2'h0;
        chk_irq();
        // a reprogrammed own address is answered from then on
        wr(`ISS_OFF_OWN_ADDR, 16'h0055);
        chk_reg(`ISS_OFF_OWN_ADDR, 16'h0055);
        master.start_cond();
        master.send_byte({7'h55, 1'b0}, ack);
        cmp({15'h0000, ack}, 16'h0000);
        master.stop_cond();
        ev = 2'h1;
        settle();
        chk_reg(`ISS_OFF_BUS_EVENT, ev_exp());
        chk_irq();
        wrap_up();
    end
endmodule
